// file: dv/spd_spi_master.sv
`timescale 1ns/100ps

// ----
// Serial master, mode 1, late sample
// ----
module spd_spi_master (
	output logic      spi_sel_n,      // Select, active low
	output logic      spi_clk,        // Serial clock
	output logic      serial_data_in, // Data to slave
	input  wire logic spi_do          // Data from slave
);
	initial
	begin
		spi_sel_n = 1'b1;
		spi_clk = 1'b0;
		serial_data_in = 1'b1;
	end

	// Offset keeps pin edges away from the system clock edge
	task automatic open_frame(output logic st);
		#13 spi_sel_n = 1'b0;
		#700 st = spi_do;
	endtask

	// Sampled at the next leading edge: slave output settles late
	task automatic shift(input logic b, output logic r);
		spi_clk = 1'b1;
		serial_data_in = b;
		#400 spi_clk = 1'b0;
		#400 r = spi_do;
	endtask

	// Clock stands low; released data line shows the inverse
	task automatic close_frame;
		spi_sel_n = 1'b1;
		serial_data_in = ~serial_data_in;
		#800;
	endtask
endmodule // spd_spi_master

// file: dv/spd_spi_slave_props.sv
`timescale 1ns/100ps

// ----
// Port checker
// ----
module spd_props (
	input wire logic        clock,                   // System clock
	input wire logic        rst_n,                   // Sync reset
	input wire logic        spi_sel_n,               // Select pin
	input wire logic        cfg_loaded,              // Config done
	input wire logic        cfg_loaded_out,          // Port operational
	input wire logic        spi_do_oe,               // Drive enable
	input wire logic        spi_irq_n,               // Interrupt
	input wire logic        application_layer_event, // Event level
	input wire logic        mem_rd_req,              // Read strobe
	input wire logic        mem_wr_valid,            // Write request
	input wire logic        mem_wr_ready,            // Write accepted
	input wire logic [15:0] mem_wr_addr,             // Write address
	input wire logic [7:0]  mem_wr_data,             // Write data
	input wire logic        pdi_err_inc,             // Error pulse
	input wire logic        access_done,             // End of access
	input wire logic        access_good              // Last verdict
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	a_err_at_done: assert property (pdi_err_inc |-> access_done)
		else $error("error pulse away from access end");
	a_err_one_pulse: assert property (pdi_err_inc |=> !pdi_err_inc)
		else $error("error pulse longer than one cycle");
	a_verdict_match: assert property (
		access_done |-> (access_good == !pdi_err_inc))
		else $error("verdict disagrees with error pulse");
	a_verdict_holds: assert property (
		!access_done |-> $stable(access_good))
		else $error("verdict changed between accesses");
	a_irq_dwell: assert property ($fell(spi_irq_n) |->
		$past(application_layer_event) && $past(application_layer_event, 2))
		else $error("interrupt raised too early");
	a_irq_release: assert property (
		!application_layer_event ##1 !application_layer_event |-> spi_irq_n)
		else $error("interrupt not released");
	a_idle_quiet: assert property (
		(spi_sel_n || !cfg_loaded) [*6] |-> !spi_do_oe)
		else $error("output driven while not selected");
	a_gate_off: assert property (
		(!cfg_loaded) [*2] |-> !cfg_loaded_out && !mem_rd_req)
		else $error("port active while not loaded");
	a_wr_held: assert property (mem_wr_valid && !mem_wr_ready |=>
		mem_wr_valid && $stable({mem_wr_addr, mem_wr_data}))
		else $error("write request dropped or changed");
	a_rd_single: assert property (mem_rd_req |=> !mem_rd_req)
		else $error("read strobe longer than one cycle");

	c_err: cover property (pdi_err_inc);
	c_stall: cover property (mem_wr_valid && !mem_wr_ready ##1 mem_wr_ready);
	c_irq: cover property ($fell(spi_irq_n));
	c_read: cover property (mem_rd_req);
endmodule // spd_props

bind spd_spi_slave spd_props u_spd_props (.clock(clock), .rst_n(rst_n),
	.spi_sel_n(spi_sel_n), .cfg_loaded(cfg_loaded),
	.cfg_loaded_out(cfg_loaded_out), .spi_do_oe(spi_do_oe),
	.spi_irq_n(spi_irq_n), .application_layer_event(application_layer_event),
	.mem_rd_req(mem_rd_req), .mem_wr_valid(mem_wr_valid),
	.mem_wr_ready(mem_wr_ready), .mem_wr_addr(mem_wr_addr),
	.mem_wr_data(mem_wr_data), .pdi_err_inc(pdi_err_inc),
	.access_done(access_done), .access_good(access_good));

// file: dv/spd_spi_slave_test.sv
`timescale 1ns/100ps

// ----
// Bench
// ----
module spd_spi_slave_test;
	import spd_pkg::*;
	logic        clock, rst_n, cfg_loaded, cfg_loaded_out, late_sample;
	logic        spi_sel_n, spi_clk, serial_data_in, spi_do, spi_do_oe;
	logic        spi_irq_n, application_layer_event, mem_rd_req, good_exp;
	logic        mem_rd_valid, mem_wr_valid, mem_wr_ready, wr_stall, st;
	logic        pdi_err_inc, access_done, access_good;
	logic [1:0]  spi_mode;
	logic [7:0]  irq_req0, irq_req1, irq_req2, mem_rd_data, mem_wr_data;
	logic [15:0] mem_rd_addr, mem_wr_addr, rd_a;
	logic [7:0]  tx [16];
	logic [7:0]  rx [16];
	logic [23:0] wq [$];
	int          fails, checks_done, n_err, rd_lat, rd_cnt, e0;

	spd_spi_slave u_spd_spi_slave (.clock, .rst_n, .spi_sel_n, .spi_clk,
		.serial_data_in, .spi_do, .spi_do_oe, .spi_irq_n, .spi_mode,
		.late_sample, .cfg_loaded, .cfg_loaded_out, .irq_req0, .irq_req1,
		.irq_req2, .application_layer_event, .mem_rd_req, .mem_rd_addr,
		.mem_rd_valid, .mem_rd_data, .mem_wr_valid, .mem_wr_addr,
		.mem_wr_data, .mem_wr_ready, .pdi_err_inc, .access_done,
		.access_good);
	spd_spi_master u_spd_spi_master (.spi_sel_n, .spi_clk, .serial_data_in,
		.spi_do);

	initial
	begin
		clock = 1'b0;
		forever #50 clock = ~clock;
	end

	// Memory side: reads answer after rd_lat cycles
	always @(posedge clock)
	begin
		mem_rd_valid <= (rd_cnt == 1);
		mem_rd_data <= rd_a[7:0] ^ 8'h5c;
		mem_wr_ready <= !wr_stall;
		rd_cnt <= (mem_rd_req === 1'b1) ? rd_lat : (rd_cnt > 0 ? rd_cnt - 1 : 0);
		if (mem_rd_req === 1'b1)
			rd_a <= mem_rd_addr;
		if (mem_wr_valid === 1'b1 && mem_wr_ready === 1'b1)
			wq.push_back({mem_wr_addr, mem_wr_data});
		if (pdi_err_inc === 1'b1)
			n_err++;
	end

	task automatic check(input logic [95:0] seen, input logic [95:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic load(input logic [63:0] v, input int n);
		for (int i = 0; i < n; i++)
			tx[i] = v[8*(n-1-i) +: 8];
	endtask

	task automatic sbyte(input logic [7:0] t, output logic [7:0] r);
		for (int k = 7; k >= 0; k--)
			u_spd_spi_master.shift(t[k], r[k]);
	endtask

	// One access: g is the byte preceded by a pause, xb stray bits
	task automatic acc(input int n, input int g, input int xb, input logic ok);
		e0 = n_err;
		wq.delete();
		u_spd_spi_master.open_frame(st);
		check(st, good_exp);
		check(spi_do_oe, 1'b1);
		for (int i = 0; i < n; i++)
		begin
			if (i == g)
				#800;
			sbyte(tx[i], rx[i]);
		end
		for (int i = 0; i < xb; i++)
			u_spd_spi_master.shift(1'b1, st);
		u_spd_spi_master.close_frame();
		repeat (6) @(posedge clock);
		check({rx[0], rx[1]}, {irq_req0, irq_req1});
		check(n_err - e0, !ok);
		good_exp = ok;
	endtask

	task automatic s_write;
		load(64'h91a45aa5, 4);
		acc(4, -1, 0, 1'b1);
		check(wq.size(), 2);
		check({wq[0], wq[1]}, 48'h12345a_1235a5);
	endtask

	task automatic s_ext;
		load(64'h2106b81077, 5);
		acc(5, -1, 0, 1'b1);
		check(rx[2], irq_req2);
		check({wq.size(), wq[0]}, {32'h1, 24'h042077});
	endtask

	task automatic s_read;
		load(64'h9803ff0000ff, 6);
		acc(6, -1, 0, 1'b1);
		check({rx[3], rx[4], rx[5]}, 24'h5c5d5e);
		load(64'h98020000ff, 5);
		acc(5, 2, 0, 1'b1);
		check({rx[2], rx[3], rx[4]}, 24'h5c5d5e);
	endtask

	task automatic s_nop;
		for (int i = 0; i < 4; i++)
		begin
			load({40'h0, 8'h98, 5'h00, 12'o7510 >> (3 * i), 8'h55}, 3);
			acc(3, -1, 0, 1'b1);
			check({wq.size(), rx[2]}, 40'hff);
		end
	endtask

	task automatic s_errors;
		load(64'h180499, 3);
		acc(3, -1, 5, 1'b0);
		check(wq.size(), 0);
		rd_lat = 10;
		load(64'h9802ff, 3);
		acc(3, -1, 0, 1'b0);
		rd_lat = 1;
		load(64'h9803ff00, 4);
		acc(4, -1, 0, 1'b0);
		load(64'h9803ffff00, 5);
		acc(5, -1, 0, 1'b0);
	endtask

	// Stalled drain overfills the buffer: RAM still written
	task automatic s_fifo;
		@(posedge clock) wr_stall <= 1'b1;
		load(64'ha004, 2);
		for (int i = 2; i < 12; i++)
			tx[i] = 8'(i);
		acc(12, -1, 0, 1'b0);
		check(wq.size(), 0);
		@(posedge clock) wr_stall <= 1'b0;
		repeat (20) @(posedge clock);
		check({wq.size() >= 8, wq[7]}, {1'b1, 24'h140709});
	endtask

	task automatic s_irq;
		@(posedge clock) application_layer_event <= 1'b1;
		@(posedge clock);
		#1 check(spi_irq_n, 1'b1);
		repeat (3) @(posedge clock);
		#1 check(spi_irq_n, 1'b0);
		@(posedge clock) application_layer_event <= 1'b0;
		repeat (2) @(posedge clock);
		#1 check(spi_irq_n, 1'b1);
	endtask

	task automatic s_gate;
		@(posedge clock) cfg_loaded <= 1'b0;
		repeat (3) @(posedge clock);
		e0 = n_err;
		wq.delete();
		u_spd_spi_master.open_frame(st);
		check(spi_do_oe, 1'b0);
		for (int i = 0; i < 3; i++)
			sbyte(8'h91, rx[i]);
		u_spd_spi_master.close_frame();
		check({wq.size(), n_err - e0, cfg_loaded_out}, 0);
		@(posedge clock) cfg_loaded <= 1'b1;
		repeat (3) @(posedge clock);
	endtask

	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	initial
	begin
		rst_n = 1'b0;
		cfg_loaded = 1'b1;
		spi_mode = 2'b01;
		late_sample = 1'b1;
		irq_req0 = 8'h3a;
		irq_req1 = 8'hc5;
		irq_req2 = 8'h96;
		application_layer_event = 1'b0;
		{wr_stall, mem_wr_ready, mem_rd_valid, mem_rd_data} = 11'h0;
		{rd_a, rd_cnt, n_err, fails, checks_done} = 0;
		rd_lat = 1;
		good_exp = 1'b1;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		repeat (4) @(posedge clock);
		s_write();
		s_ext();
		s_read();
		s_nop();
		s_errors();
		s_irq();
		s_fifo();
		s_gate();
		s_write();
		test_done();
	end

	initial
	begin
		#2000000;
		fails++;
		test_done();
	end
endmodule // spd_spi_slave_test

// file: src/spd_pkg.sv
package spd_pkg;

	localparam logic [2:0]  CMD_NOP       = 3'h0;
	localparam logic [2:0]  CMD_READ      = 3'h2;
	localparam logic [2:0]  CMD_READ_WS   = 3'h3;
	localparam logic [2:0]  CMD_WRITE     = 3'h4;
	localparam logic [2:0]  CMD_EXT       = 3'h6;
	localparam logic [15:0] IRQ_REG0_ADDR = 16'h0220;
	localparam logic [15:0] IRQ_REG1_ADDR = 16'h0221;
	localparam logic [15:0] IRQ_REG2_ADDR = 16'h0222;
	localparam logic [15:0] ERR_CNT_ADDR  = 16'h030d;
	localparam logic [15:0] REG_SPACE_END = 16'h1000;
	localparam logic [7:0]  WAIT_BYTE     = 8'hff;
	localparam logic [2:0]  LAST_BIT      = 3'h7;
	localparam logic [2:0]  PIN_RST       = 3'h5;
	localparam int          CLK_NS        = 100;
	localparam int          T_READ_NS     = 240;
	localparam int          T_IRQ_NS      = 160;
	localparam int          IRQ_DLY_CYC   = (T_IRQ_NS + CLK_NS - 1) / CLK_NS;
	localparam int          FIFO_DEPTH    = 8;
	localparam int          WR_W          = 25;

	typedef enum logic [2:0] {
		SPD_IDLE,
		SPD_ADDR,
		SPD_FETCH,
		SPD_RDATA,
		SPD_WDATA,
		SPD_SKIP
	} spd_state_t;

endpackage

// file: src/spd_spi_slave.sv
`timescale 1ns/100ps

// ----------------------------------------
// Write buffer
// ----------------------------------------
module spd_fifo #(
	parameter int WIDTH = 25,
	parameter int DEPTH = 8
) (
	input  wire logic             clock,     // System clock
	input  wire logic             rst_n,     // Sync reset
	input  wire logic             in_valid,  // Push request
	output logic                  in_ready,  // Not full
	input  wire logic [WIDTH-1:0] in_data,   // Push word
	output logic                  out_valid, // Not empty
	input  wire logic             out_ready, // Pop request
	output logic [WIDTH-1:0]      out_data   // Head word
);
	localparam int AW = $clog2(DEPTH);

	if (DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_depth
		$error("spd_fifo depth must be a power of two");
	end

	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	wire              push = in_valid && in_ready;
	wire              pop  = out_valid && out_ready;

	assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) &&
		(wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
	assign out_valid = wr_ptr != rd_ptr;
	assign out_data  = mem[rd_ptr[AW-1:0]];

	always_ff @(posedge clock)
	begin
		if (push)
			mem[wr_ptr[AW-1:0]] <= in_data;
	end

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end
		else
		begin
			wr_ptr <= wr_ptr + (AW+1)'(push);
			rd_ptr <= rd_ptr + (AW+1)'(pop);
		end
	end
endmodule // spd_fifo

// ----------------------------------------
// Serial process data port
// ----------------------------------------
module spd_spi_slave
	import spd_pkg::*;
#(
	parameter logic [15:0] REG_END = spd_pkg::REG_SPACE_END,
	parameter int          DEPTH   = spd_pkg::FIFO_DEPTH
) (
	input  wire logic        clock,         // 10 MHz system clock
	input  wire logic        rst_n,         // Sync reset
	input  wire logic        spi_sel_n,     // Select pin
	input  wire logic        spi_clk,       // Serial clock pin
	input  wire logic        serial_data_in,// Data from master
	output logic             spi_do,        // Data to master
	output logic             spi_do_oe,     // Drive enable of spi_do
	output logic             spi_irq_n,     // Interrupt to master
	input  wire logic [1:0]  spi_mode,      // [1] polarity, [0] phase
	input  wire logic        late_sample,   // Late data out sample
	input  wire logic        cfg_loaded,    // Configuration done
	output logic             cfg_loaded_out,// Port operational
	input  wire logic [7:0]  irq_req0,      // Irq register byte 0
	input  wire logic [7:0]  irq_req1,      // Irq register byte 1
	input  wire logic [7:0]  irq_req2,      // Irq register byte 2
	input  wire logic        application_layer_event, // Event level
	output logic             mem_rd_req,    // Read strobe
	output logic [15:0]      mem_rd_addr,   // Read address
	input  wire logic        mem_rd_valid,  // Read data strobe
	input  wire logic [7:0]  mem_rd_data,   // Read data
	output logic             mem_wr_valid,  // Write request
	output logic [15:0]      mem_wr_addr,   // Write address
	output logic [7:0]       mem_wr_data,   // Write data
	input  wire logic        mem_wr_ready,  // Write accepted
	output logic             pdi_err_inc,   // Error counter pulse
	output logic             access_done,   // End of access pulse
	output logic             access_good    // Side effects allowed
);
	import spd_pkg::*;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	wire  [2:0] pin_raw = {serial_data_in, spi_clk, spi_sel_n};
	logic [2:0] s1, s2, s3, pin_f;

	for (genvar i = 0; i < 3; i++)
	begin : g_sync
		always_ff @(posedge clock)
		begin
			if (!rst_n)
			begin
				s1[i]    <= PIN_RST[i];
				s2[i]    <= PIN_RST[i];
				s3[i]    <= PIN_RST[i];
				pin_f[i] <= PIN_RST[i];
			end
			else
			begin
				s1[i] <= pin_raw[i];
				s2[i] <= s1[i];
				s3[i] <= s2[i];
				if (s2[i] == s3[i])
					pin_f[i] <= s3[i];
			end
		end
	end

	// ----------------------------------------
	// Edge and byte decode
	// ----------------------------------------
	spd_state_t state;
	logic       clk_q, sel_q, show_st, good_q, err, wait_b;
	logic       fetched, term, rd_any;
	logic       fifo_in_ready;
	logic [2:0] bit_cnt;
	logic [1:0] ab_idx;
	logic [7:0] rx, tx, rd_buf;
	logic [15:0] cur_addr;
	logic [3:0] irq_cnt;

	wire cpha     = spi_mode[0];
	wire cpol     = spi_mode[1];
	wire di_f     = pin_f[2];
	wire active   = !pin_f[0] && cfg_loaded;
	wire edge_any = active && (pin_f[1] != clk_q);
	wire lead     = edge_any && (pin_f[1] != cpol);
	wire trail    = edge_any && (pin_f[1] == cpol);
	wire sample_e = cpha ? trail : lead;
	wire shift_e  = cpha ? lead : trail;
	wire start    = active && !sel_q;
	wire stop     = !active && sel_q;
	wire byte_done = sample_e && (bit_cnt == LAST_BIT);
	wire [7:0] rx_byte = {rx[6:0], di_f};
	wire in_addr  = state == SPD_ADDR;
	wire in_fetch = state == SPD_FETCH;
	wire in_rd    = state == SPD_RDATA;
	wire in_wr    = state == SPD_WDATA;

	// Command sits in byte 1 low bits or extension byte bits 4:2
	wire       first_cmd = ab_idx == 2'h1;
	wire [2:0] cmd_now   = first_cmd ? rx_byte[2:0] : rx_byte[4:2];
	wire [2:0] hi_now    = first_cmd ? 3'h0 : rx_byte[7:5];
	wire [4:0] lo_now    = first_cmd ? rx_byte[7:3] : cur_addr[4:0];
	wire [15:0] addr_now = {hi_now, cur_addr[12:5], lo_now};
	wire cmd_byte  = byte_done && in_addr && (ab_idx != 2'h0);
	wire is_read   = (cmd_now == CMD_READ) || (cmd_now == CMD_READ_WS);
	wire go_read   = cmd_byte && is_read;
	wire prefetch  = sample_e && in_rd && (bit_cnt == 3'h0) &&
		!di_f && !term;
	wire go_rd     = in_fetch && fetched && !wait_b &&
		(bit_cnt == 3'h0) && !sample_e;
	wire busy_clk  = sample_e && in_fetch && !fetched && !wait_b;
	wire extra_rd  = byte_done && in_rd && term;
	wire push      = byte_done && in_wr;
	wire overrun   = push && !fifo_in_ready;
	wire fin_err   = err || (bit_cnt != 3'h0) ||
		(in_rd && rd_any && !term);

	// Interrupt bytes per address byte; write phase output is don't care
	wire [7:0] irq_sel = (ab_idx == 2'h0) ? irq_req0 :
		(ab_idx == 2'h1) ? irq_req1 : irq_req2;
	wire [7:0] tx_src  = in_addr ? irq_sel :
		in_rd ? rd_buf : WAIT_BYTE;
	wire status_on     = cpha || late_sample;

	// ----------------------------------------
	// Access sequencing
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state    <= SPD_IDLE;
			ab_idx   <= 2'h0;
			cur_addr <= 16'h0000;
			err      <= 1'b0;
			wait_b   <= 1'b0;
			term     <= 1'b0;
			rd_any   <= 1'b0;
		end
		else if (start)
		begin
			state  <= SPD_ADDR;
			ab_idx <= 2'h0;
			err    <= 1'b0;
			term   <= 1'b0;
			rd_any <= 1'b0;
		end
		else if (stop)
			state <= SPD_IDLE;
		else
		begin
			if (busy_clk || extra_rd || overrun)
				err <= 1'b1;
			if (byte_done && in_addr && ab_idx == 2'h0)
				cur_addr[12:5] <= rx_byte;
			if (byte_done && in_addr && ab_idx != 2'h3)
				ab_idx <= ab_idx + 2'h1;
			if (cmd_byte)
			begin
				cur_addr <= addr_now;
				wait_b   <= cmd_now == CMD_READ_WS;
				if (cmd_now == CMD_EXT)
					state <= SPD_ADDR;
				else if (is_read)
				begin
					state    <= SPD_FETCH;
					cur_addr <= addr_now + 16'h1;
				end
				else if (cmd_now == CMD_WRITE)
					state <= SPD_WDATA;
				else
					state <= SPD_SKIP;
			end
			if (byte_done && in_fetch && wait_b)
			begin
				wait_b <= 1'b0;
				if (!fetched)
					err <= 1'b1;
			end
			if (go_rd)
				state <= SPD_RDATA;
			if (prefetch || push)
				cur_addr <= cur_addr + 16'h1;
			if (byte_done && in_rd)
			begin
				rd_any <= 1'b1;
				if (rx_byte == WAIT_BYTE)
					term <= 1'b1;
			end
		end
	end

	// ----------------------------------------
	// Serial shifting and status
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			clk_q   <= 1'b0;
			sel_q   <= 1'b0;
			bit_cnt <= 3'h0;
			rx      <= 8'h00;
			tx      <= 8'hff;
			show_st <= 1'b0;
		end
		else
		begin
			clk_q <= pin_f[1];
			sel_q <= active;
			if (start)
			begin
				bit_cnt <= 3'h0;
				tx      <= irq_req0;
				show_st <= status_on;
			end
			else
			begin
				if (edge_any)
					show_st <= 1'b0;
				if (sample_e)
				begin
					bit_cnt <= bit_cnt + 3'h1;
					rx      <= rx_byte;
				end
				if (go_rd)
					tx <= rd_buf;
				else if (shift_e)
					tx <= (bit_cnt == 3'h0) ? tx_src : {tx[6:0], 1'b1};
			end
		end
	end

	// ----------------------------------------
	// Internal read port
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			mem_rd_req  <= 1'b0;
			mem_rd_addr <= 16'h0000;
			fetched     <= 1'b0;
			rd_buf      <= 8'hff;
		end
		else
		begin
			mem_rd_req <= go_read || prefetch;
			if (go_read)
				mem_rd_addr <= addr_now;
			else if (prefetch)
				mem_rd_addr <= cur_addr;
			if (go_read)
				fetched <= 1'b0;
			else if (mem_rd_valid)
				fetched <= 1'b1;
			if (mem_rd_valid)
				rd_buf <= mem_rd_data;
		end
	end

	// ----------------------------------------
	// Write buffer and drain
	// ----------------------------------------
	logic              fifo_out_valid;
	logic [WR_W-1:0]   fifo_out;
	wire               push_reg  = cur_addr < REG_END;
	wire               head_reg  = fifo_out[WR_W-1];
	// Register writes wait for the verdict of the access; a new access
	// starting before they drain makes them follow its verdict instead.
	wire               take      = fifo_out_valid &&
		(!mem_wr_valid || mem_wr_ready) && !(head_reg && sel_q);
	wire               drop      = head_reg && !good_q;

	spd_fifo #(
		.WIDTH (WR_W),
		.DEPTH (DEPTH)
	) u_fifo (
		.clock     (clock),
		.rst_n     (rst_n),
		.in_valid  (push),
		.in_ready  (fifo_in_ready),
		.in_data   ({push_reg, cur_addr, rx_byte}),
		.out_valid (fifo_out_valid),
		.out_ready (take),
		.out_data  (fifo_out)
	);

	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			mem_wr_valid <= 1'b0;
			mem_wr_addr  <= 16'h0000;
			mem_wr_data  <= 8'h00;
		end
		else if (take)
		begin
			mem_wr_valid <= !drop;
			mem_wr_addr  <= fifo_out[23:8];
			mem_wr_data  <= fifo_out[7:0];
		end
		else if (mem_wr_ready)
			mem_wr_valid <= 1'b0;
	end

	// ----------------------------------------
	// Verdict, pin outputs, interrupt
	// ----------------------------------------
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			good_q         <= 1'b1;
			pdi_err_inc    <= 1'b0;
			access_done    <= 1'b0;
			access_good    <= 1'b0;
			spi_do         <= 1'b1;
			spi_do_oe      <= 1'b0;
			spi_irq_n      <= 1'b1;
			irq_cnt        <= 4'h0;
			cfg_loaded_out <= 1'b0;
		end
		else
		begin
			pdi_err_inc <= stop && fin_err;
			access_done <= stop;
			if (stop)
			begin
				good_q      <= !fin_err;
				access_good <= !fin_err;
			end
			spi_do    <= show_st ? good_q : tx[7];
			spi_do_oe <= active;
			cfg_loaded_out <= cfg_loaded;
			if (!application_layer_event)
				irq_cnt <= 4'h0;
			else if (irq_cnt != 4'(IRQ_DLY_CYC))
				irq_cnt <= irq_cnt + 4'h1;
			spi_irq_n <= !(application_layer_event &&
				irq_cnt == 4'(IRQ_DLY_CYC));
		end
	end
endmodule // spd_spi_slave
